/* File: rtl/writeable_control_store.sv */
// User control store on the microinstruction bus, loaded and dumped
// over AHB-Lite, with extension bits and a microaddress trace ring.
// Assumes microbus pins are asynchronous and held stable for at least
// three clocks around the fetch strobe; hsel comes from a bus decoder.
//
// Overview of operation
// RL1: Store holds 1024 user microword locations.
// RL2: Answer only microaddresses 2000 to 3777 octal.
// RL3: Factory microcode keeps the lower 1024 addresses.
// RL4: Answer fetches exactly like a microcode ROM.
// RL5: Load and dump via control and data registers.
// RL6: Sixteen-entry ring keeps recent fetched microaddresses.
// RL7: Each location adds extension bits 23 and 22.
// RL8: Drive current extension bits out to backplane.
// RL9: Bit 23 of a microword controls tracing.
// RL10: Four-bit control field, upper eight codes undecoded.
// RL11: Bring control field out with phase three.
// RL12: Extension bits change in step with microcycle.
// RL13: Locations are 24 bits, stored and read together.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none
module writeable_control_store (
  input  wire logic                           clock,
  input  wire logic                           rst,
  // AHB-Lite slave
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic                                hreadyout,
  output logic [31:0]                         hrdata,
  output logic                                hresp,
  // Microinstruction bus side
  input  wire logic [store_pkg::ADDR_BITS-1:0] micro_addr,
  input  wire logic                           micro_fetch,
  input  wire logic                           microcycle_phase_three_clock,
  output logic [store_pkg::STD_BITS-1:0]       microword_out,
  output logic                                microword_oe,
  // Backplane and edge-connector signals
  output logic [1:0]                          extended_control_bits,
  output logic [store_pkg::CTL_BITS-1:0]       control_field,
  output logic                                phase_three_out
);
  import store_pkg::*;

  // Pin synchronisers: first stage feeds only the second stage
  // The address word is trusted only because the pins
  // hold it steady for clocks before the strobe rises
  logic [ADDR_BITS-1:0] addr_s1_q;
  logic [ADDR_BITS-1:0] addr_s2_q;
  logic                 fetch_s1_q;
  logic                 fetch_s2_q;
  logic                 fetch_last_q;  // For edge detection
  logic                 ph3_s1_q;
  logic                 ph3_s2_q;
  logic                 ph3_last_q;    // For edge detection

  // Control/status state
  // Software owns these; the microbus only reads them
  logic                       enable_q;   // Store answers the microbus
  logic                       trace_en_q; // Trace recording allowed
  logic                       autoinc_q;  // Pointer steps on data access
  logic [STORE_ADDR_BITS-1:0] ptr_q;      // Load/dump location

  // Microbus answer state
  logic [WORD_BITS-1:0]  word_q;      // Last delivered 24-bit word
  logic                  oe_q;        // Driving the microbus
  logic                  hit_q;       // Last fetch landed in our window while enabled
  logic [ADDR_BITS-1:0]  last_addr_q; // Last fetched microaddress
  logic                  freeze_q;    // Trace frozen by a marked word
  logic [1:0]            ext_q;       // Extension bits at the backplane
  logic [CTL_BITS-1:0]   ctl_q;       // Control field at the connector

  // Bus data-phase state
  // Held through the read wait state
  logic       dp_valid_q;
  logic       dp_write_q;
  logic [7:0] dp_off_q;

  logic       rd_done_q;
  logic [31:0] hrdata_q;

  // Combinational helpers
  // Decodes and one-cycle strobes
  logic                   fetch_rise;
  logic                   ph3_rise;
  logic                   in_window;
  logic                   accept;
  logic                   wr_go;
  logic                   rd_go;
  logic                   data_access;
  logic                   csr_write;
  logic                   trace_pop;
  logic                   trace_push;

  logic [WORD_BITS-1:0]   fetch_data;
  logic [WORD_BITS-1:0]   dump_data;
  logic [ADDR_BITS-1:0]   trace_head;
  logic [TRACE_PTR_BITS-1:0] trace_idx;
  logic [31:0]            rd_mux;

  // Two-flop synchronisers for every microbus pin
  // Costs two cycles of latency on each microbus event
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_s1_q  <= '0;
      addr_s2_q  <= '0;
      fetch_s1_q <= 1'b0;
      fetch_s2_q <= 1'b0;
      ph3_s1_q   <= 1'b0;
      ph3_s2_q   <= 1'b0;
    end else begin
      addr_s1_q  <= micro_addr;
      addr_s2_q  <= addr_s1_q;
      fetch_s1_q <= micro_fetch;
      fetch_s2_q <= fetch_s1_q;
      ph3_s1_q   <= microcycle_phase_three_clock;
      ph3_s2_q   <= ph3_s1_q;
    end
  end

  // Edge history, read only from synchronised values
  // Reset to the idle pin level: no false edge after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fetch_last_q <= 1'b0;
      ph3_last_q   <= 1'b0;
    end else begin
      fetch_last_q <= fetch_s2_q;
      ph3_last_q   <= ph3_s2_q;
    end
  end

  assign fetch_rise = fetch_s2_q & ~fetch_last_q;
  assign ph3_rise   = ph3_s2_q & ~ph3_last_q;

  // Upper half of the 2048-word space; lower half stays with the ROMs
  assign in_window  = (addr_s2_q >= USER_BASE) && (addr_s2_q <= USER_TOP); // RL2 RL3

  // Storage: window offset is the low ten bits of the microaddress
  // One pointer serves both loading and dumping
  control_store_ram u_ram (
    .clock      (clock),
    .wr_en      (wr_go && (dp_off_q == OFF_DATA)),
    .wr_addr    (ptr_q),
    .wr_data    (hwdata[WORD_BITS-1:0]),
    .fetch_addr (addr_s2_q[STORE_ADDR_BITS-1:0]), // RL1
    .fetch_data (fetch_data),
    .dump_addr  (ptr_q),
    .dump_data  (dump_data)
  );

  // Microbus answer: latch the word on the strobe, release when it drops,
  // exactly as a ROM places its word for the control chip
  // A disabled store or a miss leaves the bus to the ROMs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      word_q      <= WORD_RESET;
      oe_q        <= 1'b0;
      hit_q       <= 1'b0;
      last_addr_q <= '0;
    end else if (fetch_rise) begin
      last_addr_q <= addr_s2_q;
      hit_q       <= enable_q && in_window;          // RL2
      oe_q        <= enable_q && in_window;          // RL4
      if (enable_q && in_window) begin
        word_q <= fetch_data;                        // RL13
      end
    end else if (!fetch_s2_q) begin
      // Strobe gone: stop driving, keep word for the phase-three latch
      oe_q <= 1'b0;                                  // RL4
    end
  end

  assign microword_out = word_q[STD_BITS-1:0];       // RL4
  assign microword_oe  = oe_q;

  // Extension bits and control field move only on phase three, so user
  // logic sees them timed to the microcycle rather than to bus I/O
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_q <= 2'h0;
      ctl_q <= '0;
    end else if (ph3_rise) begin
      if (hit_q) begin
        ext_q <= word_q[TRACE_BIT:EXT_LSB];          // RL7 RL12
        ctl_q <= word_q[CTL_FIELD_LSB +: CTL_BITS];  // RL10
      end else begin
        // A ROM word carries no extension; show idle values
        ext_q <= 2'h0;
        ctl_q <= '0;
      end
    end
  end

  // All sixteen codes pass out untouched; none are decoded here
  // Bus-interface codes are decoded outside this block
  assign extended_control_bits = ext_q;              // RL8
  assign control_field         = ctl_q;              // RL10 RL11
  assign phase_three_out       = ph3_s2_q;           // RL11

  // Trace: every fetched address while enabled and not frozen
  // Misses are traced too, so jumps into ROM code show up
  assign trace_push = fetch_rise && trace_en_q && !freeze_q; // RL6
  assign trace_pop  = rd_go && (dp_off_q == OFF_TRACE);

  trace_ring u_trace (
    .clock     (clock),
    .rst       (rst),
    .push      (trace_push),
    .push_addr (addr_s2_q),
    .pop       (trace_pop),
    .head      (trace_head),
    .head_idx  (trace_idx)
  );

  // Freeze when a delivered word has its trace bit set; a CSR write
  // re-arms, but a marked word in the same cycle keeps the freeze
  // Freezing keeps the history up to the marked word
  // intact until software has dumped it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      freeze_q <= 1'b0;
    end else if (ph3_rise && hit_q && word_q[TRACE_BIT]) begin
      freeze_q <= 1'b1;                              // RL9
    end else if (csr_write) begin
      freeze_q <= 1'b0;
    end
  end

  // AHB-Lite address phase; only whole-word singles are expected
  assign accept = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_off_q   <= 8'h00;
    end else if (hready) begin
      dp_valid_q <= accept;
      dp_write_q <= hwrite;
      dp_off_q   <= haddr[7:0];
    end
  end

  // Writes finish with no wait; reads take one wait state so that the
  // returned value reflects any write that just completed
  // Costs one extra cycle per read, none per write
  assign wr_go = dp_valid_q && dp_write_q;
  assign rd_go = dp_valid_q && !dp_write_q && !rd_done_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_done_q <= 1'b0;
    end else if (rd_go) begin
      rd_done_q <= 1'b1;
    end else if (hready) begin
      rd_done_q <= 1'b0;
    end
  end

  // Only a read stalls the bus, and for one cycle only
  assign hreadyout = !rd_go;

  assign hresp     = 1'b0;

  // Register selects
  // Only the low address byte is decoded, so registers
  // repeat every 256 bytes inside the select window
  assign csr_write   = wr_go && (dp_off_q == OFF_CSR);
  assign data_access = (wr_go || rd_go) && (dp_off_q == OFF_DATA);

  // Control/status register: enables and load/dump pointer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable_q   <= 1'b0;
      trace_en_q <= 1'b0;
      autoinc_q  <= 1'b0;
    end else if (csr_write) begin
      enable_q   <= hwdata[CSR_ENABLE_BIT];          // RL5
      trace_en_q <= hwdata[CSR_TRACE_BIT];
      autoinc_q  <= hwdata[CSR_AUTOINC_BIT];
    end
  end

  // Pointer: loaded from CSR, stepped after each data access if asked
  // Wraps at 1024; a full-store load needs one pointer write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ptr_q <= PTR_RESET;
    end else if (csr_write) begin
      ptr_q <= hwdata[CSR_PTR_LSB +: STORE_ADDR_BITS]; // RL5
    end else if (data_access && autoinc_q) begin
      ptr_q <= ptr_q + 1'b1;                         // RL5
    end
  end

  // Read multiplexer; unmapped offsets read as zero
  // Read once in the wait cycle, so a trace pop or a
  // pointer step happens exactly once per read
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (dp_off_q)
      OFF_CSR: begin
        rd_mux[CSR_ENABLE_BIT]  = enable_q;
        rd_mux[CSR_TRACE_BIT]   = trace_en_q;
        rd_mux[CSR_AUTOINC_BIT] = autoinc_q;
        rd_mux[CSR_PTR_LSB +: STORE_ADDR_BITS] = ptr_q;
      end
      OFF_DATA: begin
        rd_mux[WORD_BITS-1:0] = dump_data;           // RL5 RL13
      end
      OFF_TRACE: begin
        rd_mux[ADDR_BITS-1:0] = trace_head;          // RL6
        rd_mux[TRACE_IDX_LSB +: TRACE_PTR_BITS] = trace_idx;
      end
      OFF_STATUS: begin
        rd_mux[ADDR_BITS-1:0]          = last_addr_q;
        rd_mux[STAT_FREEZE_BIT]        = freeze_q;
        rd_mux[STAT_HIT_BIT]           = hit_q;
        rd_mux[STAT_EXT_LSB +: 2]      = ext_q;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Read data held in a flop from the wait cycle onward
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata_q <= RDATA_RESET;
    end else if (rd_go) begin
      hrdata_q <= rd_mux;
    end
  end

  assign hrdata = hrdata_q;
endmodule : writeable_control_store
`default_nettype wire

/* File: rtl/store_pkg.sv */
// Package for the user control store: sizes, field positions,
// register offsets and reset values.
// Assumes a 32-bit AHB-Lite register bus and an 11-bit microaddress.
package store_pkg;
  // Store geometry
  localparam int STORE_DEPTH     = 1024;
  localparam int STORE_ADDR_BITS = 10;
  localparam int ADDR_BITS       = 11;
  localparam int WORD_BITS       = 24;
  localparam int STD_BITS        = 22;
  // User window of the microaddress space
  localparam logic [10:0] USER_BASE = 11'h400;  // 2000 octal
  localparam logic [10:0] USER_TOP  = 11'h7ff;  // 3777 octal
  // Microword fields
  localparam int TRACE_BIT     = 23;
  localparam int EXT_LSB       = 22;
  localparam int CTL_FIELD_LSB = 18;
  localparam int CTL_BITS      = 4;
  // Trace ring
  localparam int TRACE_DEPTH    = 16;
  localparam int TRACE_PTR_BITS = 4;
  // Register byte offsets
  localparam logic [7:0] OFF_CSR    = 8'h00;
  localparam logic [7:0] OFF_DATA   = 8'h04;
  localparam logic [7:0] OFF_TRACE  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  // Control/status register fields
  localparam int CSR_ENABLE_BIT  = 0;
  localparam int CSR_TRACE_BIT   = 1;
  localparam int CSR_AUTOINC_BIT = 2;
  localparam int CSR_PTR_LSB     = 16;
  // Status register fields
  localparam int STAT_FREEZE_BIT = 16;
  localparam int STAT_HIT_BIT    = 17;
  localparam int STAT_EXT_LSB    = 20;
  // Trace read field
  localparam int TRACE_IDX_LSB = 16;
  // Reset values
  localparam logic [9:0]  PTR_RESET  = 10'h000;
  localparam logic [23:0] WORD_RESET = 24'h000000;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;
  // Transfer type with the address-phase bit
  localparam int HTRANS_ACTIVE_BIT = 1;
endpackage : store_pkg

/* File: rtl/control_store_ram.sv */
// Microword memory: one write port, two combinational read ports.
// Assumes writes only come from the register bus side.
`timescale 1ns/1ps
`default_nettype none
module control_store_ram (
  input  wire logic                                 clock,
  input  wire logic                                 wr_en,
  input  wire logic [store_pkg::STORE_ADDR_BITS-1:0] wr_addr,
  input  wire logic [store_pkg::WORD_BITS-1:0]       wr_data,
  input  wire logic [store_pkg::STORE_ADDR_BITS-1:0] fetch_addr,
  output logic      [store_pkg::WORD_BITS-1:0]       fetch_data,
  input  wire logic [store_pkg::STORE_ADDR_BITS-1:0] dump_addr,
  output logic      [store_pkg::WORD_BITS-1:0]       dump_data
);
  import store_pkg::*;

  // Full 24-bit locations, standard word and extension kept together
  logic [WORD_BITS-1:0] mem [STORE_DEPTH];

  // Write port; contents are undefined until software loads them
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read ports for microbus fetch and register dump
  assign fetch_data = mem[fetch_addr];
  assign dump_data  = mem[dump_addr];
endmodule : control_store_ram
`default_nettype wire

/* File: rtl/trace_ring.sv */
// Sixteen-entry recirculating microaddress trace ring.
// Assumes push and pop are one-cycle pulses from the same clock.
`timescale 1ns/1ps
`default_nettype none
module trace_ring (
  input  wire logic                                clock,
  input  wire logic                                rst,
  input  wire logic                                push,
  input  wire logic [store_pkg::ADDR_BITS-1:0]      push_addr,
  input  wire logic                                pop,
  output logic      [store_pkg::ADDR_BITS-1:0]      head,
  output logic      [store_pkg::TRACE_PTR_BITS-1:0] head_idx
);
  import store_pkg::*;

  logic [ADDR_BITS-1:0]      ring [TRACE_DEPTH];  // Entries
  logic [TRACE_PTR_BITS-1:0] wr_ptr_q;            // Next slot, also oldest
  logic [TRACE_PTR_BITS-1:0] rd_ptr_q;            // Dump cursor

  // Overwrite the oldest entry with every new address
  always_ff @(posedge clock) begin
    if (push) begin
      ring[wr_ptr_q] <= push_addr;
    end
  end

  // Pointers wrap naturally at sixteen; a push re-aims the cursor at the
  // oldest entry so a dump always walks oldest to newest
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else if (push) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
      rd_ptr_q <= wr_ptr_q + 1'b1;
    end else if (pop) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  assign head     = ring[rd_ptr_q];
  assign head_idx = rd_ptr_q;
endmodule : trace_ring
`default_nettype wire

/* File: bench/wcs_props.sv */
// Checker for the control store: register bus and microbus timing.
// Sees only top-level ports; one clock, async active-high reset.
`timescale 1ns/1ps
`default_nettype none
module control_store_props (
  input wire logic                            clock,
  input wire logic                            rst,
  input wire logic                            hsel,
  input wire logic [1:0]                      htrans,
  input wire logic                            hwrite,
  input wire logic                            hready,
  input wire logic                            hreadyout,
  input wire logic [31:0]                     hrdata,
  input wire logic                            hresp,
  input wire logic [store_pkg::ADDR_BITS-1:0] micro_addr,
  input wire logic                            micro_fetch,
  input wire logic                            microcycle_phase_three_clock,
  input wire logic [store_pkg::STD_BITS-1:0]  microword_out,
  input wire logic                            microword_oe,
  input wire logic [1:0]                      extended_control_bits,
  input wire logic [store_pkg::CTL_BITS-1:0]  control_field,
  input wire logic                            phase_three_out
);
  import store_pkg::*;
  // All checks share the bus clock and its reset
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Response never signals an error
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not OKAY");
  // A read inserts exactly one wait cycle
  property p_rd_wait; hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  // A write completes with no wait
  property p_wr_nowait; hsel && htrans[1] && hready && hwrite |=> hreadyout; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write waited");
  // Read data holds outside wait cycles
  property p_rd_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("hrdata moved");
  // Store drives only inside its own address window
  property p_window; $rose(microword_oe) |-> $past(micro_addr, 4) >= USER_BASE; endproperty
  a_window: assert property (p_window) else $error("answered outside window");
  // Drive starts three edges after the strobe rises, like a ROM
  property p_oe_on; $rose(microword_oe) |-> $past(micro_fetch, 3) && !$past(micro_fetch, 4); endproperty
  a_oe_on: assert property (p_oe_on) else $error("drive start late or early");
  // Drive ends three edges after the strobe falls
  property p_oe_off; $fell(microword_oe) |-> !$past(micro_fetch, 3) && $past(micro_fetch, 4); endproperty
  a_oe_off: assert property (p_oe_off) else $error("drive end wrong");
  // Word on the bus holds while driven
  property p_word_hold; microword_oe && $past(microword_oe) |-> $stable(microword_out); endproperty
  a_word_hold: assert property (p_word_hold) else $error("word moved");
  // Extension bits move only three edges after a phase-three rise
  property p_ext_step; $changed(extended_control_bits) |->
    $past(microcycle_phase_three_clock, 3) && !$past(microcycle_phase_three_clock, 4); endproperty
  a_ext_step: assert property (p_ext_step) else $error("ext bits off cycle");
  // Control field moves in step with phase three
  property p_ctl_step; $changed(control_field) |->
    $past(microcycle_phase_three_clock, 3) && !$past(microcycle_phase_three_clock, 4); endproperty
  a_ctl_step: assert property (p_ctl_step) else $error("field off cycle");
  // Phase three reaches the connector two edges after the pin
  property p_phase_out; phase_three_out == $past(microcycle_phase_three_clock, 2); endproperty
  a_phase_out: assert property (p_phase_out) else $error("phase three out late");
endmodule : control_store_props
bind writeable_control_store control_store_props u_control_store_props (.clock, .rst,
  .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hrdata, .hresp, .micro_addr, .micro_fetch,
  .microcycle_phase_three_clock, .microword_out, .microword_oe,
  .extended_control_bits, .control_field, .phase_three_out);
`default_nettype wire

/* File: bench/micro_bus_model.sv */
// Model of the microprocessor side of the microinstruction bus.
// Fetch and phase-three tasks are called by the bench.
`timescale 1ns/1ps
`default_nettype none
module micro_bus_model (
  input  wire logic        clock,
  output logic      [10:0] micro_addr,
  output logic             micro_fetch,
  output logic             phase3,
  input  wire logic [21:0] microword_out,
  input  wire logic        microword_oe
);
  // Idle bus at time zero
  initial begin
    micro_addr  = 11'h000;
    micro_fetch = 1'b0;
    phase3      = 1'b0;
  end
  // ROM style fetch: address settles before the strobe; word taken late
  task automatic fetch(input logic [10:0] a, output logic [21:0] w, output logic oe);
    @(posedge clock);
    micro_addr <= a;
    repeat (3) @(posedge clock);
    micro_fetch <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    w  = microword_out;
    oe = microword_oe;
    @(posedge clock);
    micro_fetch <= 1'b0;
    repeat (5) @(posedge clock);
    // Released lines show the inverse so stale values cannot pass
    micro_addr <= ~a;
  endtask : fetch
  // One phase-three pulse of two clocks, then quiet time
  task automatic pulse();
    @(posedge clock);
    phase3 <= 1'b1;
    repeat (2) @(posedge clock);
    phase3 <= 1'b0;
    repeat (5) @(posedge clock);
  endtask : pulse
endmodule : micro_bus_model
`default_nettype wire

/* File: bench/writeable_control_store_tb.sv */
// Self-checking bench: AHB-Lite master, microbus model, three scenarios.
// Assumes a single slave, so hready is the slave's hreadyout.
`timescale 1ns/1ps
`default_nettype none
module writeable_control_store_tb;
  import store_pkg::*;
  logic        clock;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize = 3'b010; // Word transfers only
  logic [31:0] hwdata;
  wire         hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [10:0] micro_addr;
  logic        micro_fetch;
  logic        phase3;
  logic [21:0] microword_out;
  logic        microword_oe;
  logic [1:0]  ext;
  logic [3:0]  cf;
  int          failures = 0;
  int          checked = 0;
  assign hready = hreadyout;
  writeable_control_store u_writeable_control_store (.clock(clock), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .micro_addr(micro_addr), .micro_fetch(micro_fetch),
    .microcycle_phase_three_clock(phase3), .microword_out(microword_out),
    .microword_oe(microword_oe), .extended_control_bits(ext), .control_field(cf),
    .phase_three_out());
  micro_bus_model u_micro_bus_model (.clock(clock), .micro_addr(micro_addr),
    .micro_fetch(micro_fetch), .phase3(phase3), .microword_out(microword_out),
    .microword_oe(microword_oe));
  // Free-running 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic final_report();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One single AHB-Lite transfer; waits on hready at both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge clock iff hready === 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock iff hready === 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    ahb(1'b0, a, 32'h0, r);
  endtask : rd
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    rd(a, r);
    chk(r, e);
  endtask : chk_rd
  // Control word: enable, trace, auto-increment always on, pointer
  function automatic logic [31:0] csr(logic en, logic tr, logic [9:0] p);
    return {6'h0, p, 13'h0, 1'b1, tr, en};
  endfunction : csr
  // Test word for a location; location 16 carries the trace marker bit
  function automatic logic [23:0] wd(int i);
    logic [7:0] b;
    b = i[7:0];
    return (i == 16) ? 24'hc5a5a5 : {2'b01, 6'h15, b, ~b};
  endfunction : wd
  // Load and dump, pointer wrap, 24-bit width, unmapped offset
  task automatic t_load();
    wr(OFF_CSR, csr(1'b0, 1'b0, 10'h3ff));
    wr(OFF_DATA, 32'hffabcdef);
    wr(OFF_DATA, 32'h00123456);
    chk_rd(OFF_CSR, csr(1'b0, 1'b0, 10'h001));
    wr(OFF_CSR, csr(1'b0, 1'b0, 10'h3ff));
    chk_rd(OFF_DATA, 32'h00abcdef);
    chk_rd(OFF_DATA, 32'h00123456);
    wr(OFF_CSR, csr(1'b0, 1'b0, 10'h000));
    for (int i = 0; i < 20; i++) wr(OFF_DATA, {8'hff, wd(i)});
    wr(OFF_CSR, csr(1'b0, 1'b0, 10'h000));
    for (int i = 0; i < 20; i++) chk_rd(OFF_DATA, {8'h0, wd(i)});
    chk_rd(8'h10, 32'h0);
  endtask : t_load
  // Fetch hits, a miss below the window, a disabled store, ext bits out
  task automatic t_fetch();
    logic [21:0] w;
    logic        oe;
    logic [23:0] x;
    wr(OFF_CSR, csr(1'b1, 1'b0, 10'h000));
    for (int k = 2; k <= 16; k += 14) begin
      x = wd(k);
      u_micro_bus_model.fetch(11'h400 + 11'(k), w, oe);
      chk(32'(oe), 32'h1);
      chk(32'(w), 32'(x[21:0]));
      u_micro_bus_model.pulse();
      chk(32'(ext), 32'(x[23:22]));
      chk(32'(cf), 32'(x[21:18]));
    end
    u_micro_bus_model.fetch(11'h3ff, w, oe);
    chk(32'(oe), 32'h0);
    u_micro_bus_model.pulse();
    chk(32'(ext), 32'h0);
    wr(OFF_CSR, csr(1'b0, 1'b0, 10'h000));
    u_micro_bus_model.fetch(11'h402, w, oe);
    chk(32'(oe), 32'h0);
  endtask : t_fetch
  // Ring keeps the last sixteen; marker bit freezes it
  task automatic t_trace();
    logic [21:0] w;
    logic        oe;
    logic [31:0] r;
    wr(OFF_CSR, csr(1'b1, 1'b1, 10'h000));
    for (int k = 0; k <= 16; k++) u_micro_bus_model.fetch(11'h400 + 11'(k), w, oe);
    u_micro_bus_model.pulse();
    u_micro_bus_model.fetch(11'h401, w, oe);
    rd(OFF_STATUS, r);
    chk(32'(r[STAT_FREEZE_BIT]), 32'h1);
    chk(r, 32'h00330401);
    for (int k = 1; k <= 17; k++) begin
      rd(OFF_TRACE, r);
      chk(r & 32'hf07ff, ((k % 16) << 16) + 32'h400 + ((k - 1) % 16) + 1);
    end
  endtask : t_trace
  // Main sequence: reset for sixteen clocks, then the scenarios
  initial begin
    rst    = 1'b1;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_load();
    t_fetch();
    t_trace();
    final_report();
  end
  // Watchdog well beyond the expected run of about 630 cycles
  initial begin
    #60000;
    failures++;
    final_report();
  end
endmodule : writeable_control_store_tb
`default_nettype wire
